// [rtl/qsc_top.v]
// Quadrature status, flags and counters with hold registers for coherent access.
// Summary of operation
// - I/O control bit 2 shows the marker pin after polarity inversion.
// - I/O control bits 1 and 0 show phases B and A after inversion and exchange.
// - Upper compare flag sets while position is at or above the upper value.
// - Lower compare flag sets while position is at or below the lower value.
// - Position overflow flag sets whenever the position counter wraps.
// - Homing flag sets when the homing process reloads the position counter.
// - Homing flag acts only in first-marker or second-marker after home modes.
// - Velocity overflow flag sets whenever the velocity counter wraps.
// - Home event flag sets on every home input event.
// - Marker event flag sets on every marker input event.
// - Each flag has an enable one bit lower gating its interrupt request.
// - Flags are set by hardware, cleared by software, zero after reset.
// - Status bits 15 and 14 always read as zero.
// - Position count is 32 bits, as writable high and low words, reset zero.
// - A 16-bit position hold register carries the high word for software.
// - A 16-bit writable velocity count is cleared at reset.
// - Marker count is 32 bits, as writable high and low words, reset zero.
// - A 16-bit marker hold register carries the marker high word for software.
// - Mode 011 loads the init value on the first marker after home.
// - Mode 100 loads the init value on the second marker after home.
`include "qsc_map.vh"
`timescale 1ns/10ps
`default_nettype none

module qsc_top (
   // Clock, reset and clock enable.
   input  wire        clk_i,
   input  wire        reset_i,
   input  wire        ce_i,
   // Register port.
   input  wire [3:0]  reg_addr_i,
   input  wire [15:0] reg_wdata_i,
   input  wire        reg_write_i,
   input  wire        reg_read_i,
   output wire [15:0] reg_rdata_o,
   // Encoder pins.
   input  wire        phase_a_pin_i,
   input  wire        phase_b_pin_i,
   input  wire        marker_pin_i,
   input  wire        home_pin_i,
   // Decoder and configuration logic on the same clock.
   input  wire        count_up_i,
   input  wire        count_down_i,
   input  wire [2:0]  position_init_select_i,
   input  wire [31:0] upper_compare_value_i,
   input  wire [31:0] lower_compare_value_i,
   input  wire [31:0] init_capture_value_i,
   // Conditioned levels and interrupt requests.
   output wire        phase_a_level_o,
   output wire        phase_b_level_o,
   output wire [6:0]  irq_req_o
);

   // Homing sequence states; a home event seen while armed is ignored until done.
   localparam [1:0] HM_IDLE  = 2'h0;
   localparam [1:0] HM_HOMED = 2'h1;
   localparam [1:0] HM_ONE   = 2'h2;

   // Up/down step of a 32-bit counter; bit 32 flags a wrap.
   // Both pulses at once cancel, so a confused decoder cannot move the count.
   function [32:0] step32;
      input [31:0] cnt;
      input        up;
      input        dn;
      begin
         if (up && !dn)
            step32 = {(cnt == 32'hffff_ffff), cnt + 32'h0000_0001};
         else if (dn && !up)
            step32 = {(cnt == 32'h0000_0000), cnt - 32'h0000_0001};
         else
            step32 = {1'b0, cnt};
      end
   endfunction

   // Up/down step of a 16-bit counter; bit 16 flags a wrap.
   function [16:0] step16;
      input [15:0] cnt;
      input        up;
      input        dn;
      begin
         if (up && !dn)
            step16 = {(cnt == 16'hffff), cnt + 16'h0001};
         else if (dn && !up)
            step16 = {(cnt == 16'h0000), cnt - 16'h0001};
         else
            step16 = {1'b0, cnt};
      end
   endfunction

   // Register select: true when a qualified strobe targets the given word address.
   function sel;
      input       stb;
      input [3:0] addr;
      input [3:0] target;
      begin
         sel = stb && (addr == target);
      end
   endfunction

   reg  [3:0]  sync1_r;
   reg  [3:0]  sync2_r;
   reg  [15:0] ioc_r;
   reg  [6:0]  flag_r;
   reg  [6:0]  flag_nxt;
   reg  [6:0]  en_r;
   reg  [6:0]  irq_r;
   reg  [31:0] pos_r;
   reg  [31:0] pos_nxt;
   reg  [15:0] pos_hold_r;
   reg  [15:0] vel_r;
   reg  [15:0] vel_nxt;
   reg  [31:0] mark_r;
   reg  [31:0] mark_nxt;
   reg  [15:0] mark_hold_r;
   reg  [1:0]  hm_r;
   reg  [1:0]  hm_nxt;
   reg         mark_prev_r;
   reg         home_prev_r;
   reg  [15:0] rdata_r;
   reg  [15:0] rdata_nxt;
   reg  [15:0] status_val;
   reg  [6:0]  ev_set;
   reg         homing_load;
   reg  [32:0] pos_step;
   reg  [16:0] vel_step;
   reg  [32:0] mark_step;
   integer     k;
   integer     j;

   // Polarity first, then the optional exchange of the two phases.
   wire        a_inv    = sync2_r[0] ^ ioc_r[`QSC_IOC_A_POL_BIT];
   wire        b_inv    = sync2_r[1] ^ ioc_r[`QSC_IOC_B_POL_BIT];
   wire        mark_lvl = sync2_r[2] ^ ioc_r[`QSC_IOC_MARK_POL_BIT];
   wire        home_lvl = sync2_r[3] ^ ioc_r[`QSC_IOC_HOME_POL_BIT];
   wire        a_lvl    = ioc_r[`QSC_IOC_EXCHANGE_BIT] ? b_inv : a_inv;
   wire        b_lvl    = ioc_r[`QSC_IOC_EXCHANGE_BIT] ? a_inv : b_inv;
   // Edge detectors start low: changing a polarity bit while a pin rests can read as an
   // event, so software should clear the status after reconfiguring the pins.
   wire        mark_ev  = mark_lvl & ~mark_prev_r;
   wire        home_ev  = home_lvl & ~home_prev_r;
   wire        wr       = ce_i & reg_write_i;
   wire        rd       = ce_i & reg_read_i;

   // Per-register strobes, decoded once so every process sees the same select.
   wire        wr_ioc       = sel(wr, reg_addr_i, `QSC_ADDR_IO_CONTROL);
   wire        wr_status    = sel(wr, reg_addr_i, `QSC_ADDR_STATUS);
   wire        wr_pos_high  = sel(wr, reg_addr_i, `QSC_ADDR_POS_HIGH);
   wire        wr_pos_low   = sel(wr, reg_addr_i, `QSC_ADDR_POS_LOW);
   wire        wr_pos_hold  = sel(wr, reg_addr_i, `QSC_ADDR_POS_HOLD);
   wire        wr_velocity  = sel(wr, reg_addr_i, `QSC_ADDR_VELOCITY);
   wire        wr_mark_high = sel(wr, reg_addr_i, `QSC_ADDR_MARK_HIGH);
   wire        wr_mark_low  = sel(wr, reg_addr_i, `QSC_ADDR_MARK_LOW);
   wire        wr_mark_hold = sel(wr, reg_addr_i, `QSC_ADDR_MARK_HOLD);
   wire        rd_status    = sel(rd, reg_addr_i, `QSC_ADDR_STATUS);
   wire        rd_pos_low   = sel(rd, reg_addr_i, `QSC_ADDR_POS_LOW);
   wire        rd_mark_low  = sel(rd, reg_addr_i, `QSC_ADDR_MARK_LOW);
   wire        homing_mode = (position_init_select_i == `QSC_INIT_FIRST_MARK) ||
                             (position_init_select_i == `QSC_INIT_SECOND_MARK);

   // Homing sequence: a home event arms it, markers then advance it.
   always @* begin
      hm_nxt = hm_r;
      homing_load = 1'b0;
      if (!homing_mode) begin
         hm_nxt = HM_IDLE;
      end else begin
         case (hm_r)
            HM_IDLE: begin
               if (home_ev)
                  hm_nxt = HM_HOMED;
            end
            HM_HOMED: begin
               if (mark_ev) begin
                  if (position_init_select_i == `QSC_INIT_FIRST_MARK) begin
                     homing_load = 1'b1;
                     hm_nxt = HM_IDLE;
                  end else begin
                     hm_nxt = HM_ONE;
                  end
               end
            end
            HM_ONE: begin
               if (mark_ev) begin
                  homing_load = 1'b1;
                  hm_nxt = HM_IDLE;
               end
            end
            default: begin
               hm_nxt = HM_IDLE;
            end
         endcase
      end
   end

   // Position count; a homing reload beats a software write, which beats counting.
   always @* begin
      pos_step = step32(pos_r, count_up_i, count_down_i);
      pos_nxt  = pos_step[31:0];
      if (homing_load) begin
         pos_nxt = init_capture_value_i;
      end else if (wr_pos_low) begin
         pos_nxt = {pos_hold_r, reg_wdata_i};
      end else if (wr_pos_high) begin
         pos_nxt = {reg_wdata_i, pos_r[15:0]};
      end
   end

   // Velocity and marker counts; a software write beats the count of that cycle.
   always @* begin
      vel_step  = step16(vel_r, count_up_i, count_down_i);
      mark_step = step32(mark_r, mark_ev, 1'b0);
      vel_nxt   = vel_step[15:0];
      mark_nxt  = mark_step[31:0];
      if (wr_velocity)
         vel_nxt = reg_wdata_i;
      if (wr_mark_low) begin
         mark_nxt = {mark_hold_r, reg_wdata_i};
      end else if (wr_mark_high) begin
         mark_nxt = {reg_wdata_i, mark_r[15:0]};
      end
   end

   // Flag sources of this cycle.
   always @* begin
      ev_set = `QSC_RST_EVENTS;
      ev_set[`QSC_EV_UPPER]   = (pos_r >= upper_compare_value_i);
      ev_set[`QSC_EV_LOWER]   = (pos_r <= lower_compare_value_i);
      ev_set[`QSC_EV_POS_OVF] = pos_step[32] & ~homing_load;
      ev_set[`QSC_EV_HOMING]  = homing_load;
      ev_set[`QSC_EV_VEL_OVF] = vel_step[16];
      ev_set[`QSC_EV_HOME]    = home_ev;
      ev_set[`QSC_EV_MARKER]  = mark_ev;
   end

   // Status image: each flag on an odd bit, its enable just below it.
   always @* begin
      status_val = `QSC_RST_WORD;
      for (k = 0; k < `QSC_EV_COUNT; k = k + 1) begin
         status_val[2*k+1] = flag_r[k];
         status_val[2*k]   = en_r[k];
      end
   end

   // Next flags; an event in the read cycle keeps its flag, so no event is lost.
   always @* begin
      flag_nxt = flag_r;
      if (rd_status)
         flag_nxt = `QSC_RST_EVENTS;
      flag_nxt = flag_nxt | ev_set;
   end

   // Read data, presented in the cycle after the strobe.
   always @* begin
      rdata_nxt = `QSC_RST_WORD;
      case (reg_addr_i)
         `QSC_ADDR_IO_CONTROL: begin
            rdata_nxt = ioc_r & `QSC_IOC_RW_MASK;
            rdata_nxt[`QSC_IOC_HOME_LVL_BIT] = home_lvl;
            rdata_nxt[`QSC_IOC_MARK_LVL_BIT] = mark_lvl;
            rdata_nxt[`QSC_IOC_B_LVL_BIT]    = b_lvl;
            rdata_nxt[`QSC_IOC_A_LVL_BIT]    = a_lvl;
         end
         `QSC_ADDR_STATUS:    rdata_nxt = status_val;
         `QSC_ADDR_POS_HIGH:  rdata_nxt = pos_r[31:16];
         `QSC_ADDR_POS_LOW:   rdata_nxt = pos_r[15:0];
         `QSC_ADDR_POS_HOLD:  rdata_nxt = pos_hold_r;
         `QSC_ADDR_VELOCITY:  rdata_nxt = vel_r;
         `QSC_ADDR_MARK_HIGH: rdata_nxt = mark_r[31:16];
         `QSC_ADDR_MARK_LOW:  rdata_nxt = mark_r[15:0];
         `QSC_ADDR_MARK_HOLD: rdata_nxt = mark_hold_r;
         default:             rdata_nxt = `QSC_RST_WORD;
      endcase
   end

   // Pins pass two flip-flops; only the second stage feeds the logic.
   always @(posedge clk_i) begin
      if (reset_i) begin
         sync1_r <= 4'h0;
         sync2_r <= 4'h0;
      end else if (ce_i) begin
         sync1_r <= {home_pin_i, marker_pin_i, phase_b_pin_i, phase_a_pin_i};
         sync2_r <= sync1_r;
      end
   end

   // Edge detectors and homing sequence state.
   always @(posedge clk_i) begin
      if (reset_i) begin
         hm_r        <= HM_IDLE;
         mark_prev_r <= 1'b0;
         home_prev_r <= 1'b0;
      end else if (ce_i) begin
         mark_prev_r <= mark_lvl;
         home_prev_r <= home_lvl;
         hm_r        <= hm_nxt;
      end
   end

   // Position, velocity and marker counts.
   always @(posedge clk_i) begin
      if (reset_i) begin
         pos_r  <= `QSC_RST_COUNT;
         vel_r  <= `QSC_RST_WORD;
         mark_r <= `QSC_RST_COUNT;
      end else if (ce_i) begin
         pos_r  <= pos_nxt;
         vel_r  <= vel_nxt;
         mark_r <= mark_nxt;
      end
   end

   // Event flags and the per-event requests, registered from this cycle's events and enables.
   always @(posedge clk_i) begin
      if (reset_i) begin
         flag_r <= `QSC_RST_EVENTS;
         irq_r  <= `QSC_RST_EVENTS;
      end else if (ce_i) begin
         flag_r <= flag_nxt;
         irq_r  <= ev_set & en_r;
      end
   end

   // Read data stand one cycle and return to zero, so a stale word is never seen.
   always @(posedge clk_i) begin
      if (reset_i) begin
         rdata_r <= `QSC_RST_WORD;
      end else if (ce_i) begin
         if (reg_read_i)
            rdata_r <= rdata_nxt;
         else
            rdata_r <= `QSC_RST_WORD;
      end
   end

   // Software configuration: pin control and interrupt enables.
   always @(posedge clk_i) begin
      if (reset_i) begin
         ioc_r <= `QSC_RST_WORD;
         en_r  <= `QSC_RST_EVENTS;
      end else if (ce_i) begin
         if (wr_ioc)
            ioc_r <= reg_wdata_i & `QSC_IOC_RW_MASK;
         if (wr_status) begin
            for (j = 0; j < `QSC_EV_COUNT; j = j + 1)
               en_r[j] <= reg_wdata_i[2*j];
         end
      end
   end

   // Hold registers; a software write to a hold wins over the latch of a low-word read.
   always @(posedge clk_i) begin
      if (reset_i) begin
         pos_hold_r  <= `QSC_RST_WORD;
         mark_hold_r <= `QSC_RST_WORD;
      end else if (ce_i) begin
         if (wr_pos_hold)
            pos_hold_r <= reg_wdata_i;
         else if (rd_pos_low)
            pos_hold_r <= pos_r[31:16];
         if (wr_mark_hold)
            mark_hold_r <= reg_wdata_i;
         else if (rd_mark_low)
            mark_hold_r <= mark_r[31:16];
      end
   end

   // Levels come straight from flops through polarity logic; requests are registered.
   assign reg_rdata_o     = rdata_r;
   assign phase_a_level_o = a_lvl;
   assign phase_b_level_o = b_lvl;
   assign irq_req_o       = irq_r;

endmodule

`default_nettype wire

// [rtl/qsc_map.vh]
// Register map, field positions and reset values of the quadrature status counters.
`ifndef QSC_MAP_VH
`define QSC_MAP_VH

// Register word addresses on the plain register port.
`define QSC_ADDR_IO_CONTROL   4'h0
`define QSC_ADDR_STATUS       4'h1
`define QSC_ADDR_POS_HIGH     4'h2
`define QSC_ADDR_POS_LOW      4'h3
`define QSC_ADDR_POS_HOLD     4'h4
`define QSC_ADDR_VELOCITY     4'h5
`define QSC_ADDR_MARK_HIGH    4'h6
`define QSC_ADDR_MARK_LOW     4'h7
`define QSC_ADDR_MARK_HOLD    4'h8

// I/O control register fields.
`define QSC_IOC_EXCHANGE_BIT  8
`define QSC_IOC_HOME_POL_BIT  7
`define QSC_IOC_MARK_POL_BIT  6
`define QSC_IOC_B_POL_BIT     5
`define QSC_IOC_A_POL_BIT     4
`define QSC_IOC_HOME_LVL_BIT  3
`define QSC_IOC_MARK_LVL_BIT  2
`define QSC_IOC_B_LVL_BIT     1
`define QSC_IOC_A_LVL_BIT     0
`define QSC_IOC_RW_MASK       16'hfff0

// Event index k: flag at status bit 2k+1, enable at status bit 2k.
`define QSC_EV_UPPER          6
`define QSC_EV_LOWER          5
`define QSC_EV_POS_OVF        4
`define QSC_EV_HOMING         3
`define QSC_EV_VEL_OVF        2
`define QSC_EV_HOME           1
`define QSC_EV_MARKER         0
`define QSC_EV_COUNT          7

// Reset values.
`define QSC_RST_WORD          16'h0000
`define QSC_RST_COUNT         32'h0000_0000
`define QSC_RST_EVENTS        7'h00

// Position initialisation modes handled here.
`define QSC_INIT_FIRST_MARK   3'h3
`define QSC_INIT_SECOND_MARK  3'h4

`endif

// [sim/qsc_enc_model.sv]
// Encoder pin model: quadrature phase levels, marker and home pulses.
`timescale 1ns/10ps
`default_nettype none
module qsc_enc_model (
   // Clock.
   input  wire logic clk_i,
   // Encoder pins.
   output var logic  phase_a_pin_o,
   output var logic  phase_b_pin_o,
   output var logic  marker_pin_o,
   output var logic  home_pin_o
);
   initial begin
      {phase_a_pin_o, phase_b_pin_o, marker_pin_o, home_pin_o} = 4'h0;
   end
   task automatic set_ab(input logic [1:0] ab);
      {phase_a_pin_o, phase_b_pin_o} = ab;
   endtask
   // Pins move off the edge and stay four cycles, so the synchroniser cannot miss them.
   task automatic pulse(input logic mark);
      @(posedge clk_i);
      #7;
      if (mark) marker_pin_o = 1'b1;
      else home_pin_o = 1'b1;
      repeat (4) @(posedge clk_i);
      #7 {marker_pin_o, home_pin_o} = 2'h0;
      repeat (4) @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

// [sim/qsc_top_chk.sv]
// Concurrent checks on the ports of the quadrature status counters.
`timescale 1ns/10ps
`default_nettype none
module qsc_top_chk (
   // Clock, reset and register port.
   input wire logic        clk_i,
   input wire logic        reset_i,
   input wire logic        ce_i,
   input wire logic [3:0]  reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic        reg_write_i,
   input wire logic        reg_read_i,
   input wire logic [15:0] reg_rdata_o,
   // Levels, requests and mode.
   input wire logic        phase_a_level_o,
   input wire logic        phase_b_level_o,
   input wire logic [6:0]  irq_req_o,
   input wire logic [2:0]  position_init_select_i
);
   logic [6:0] en_r;
   logic [6:0] en_nxt;
   logic       st_wr;
   logic [15:0] en_word;
   assign en_word = {3'h0, en_r[6], 1'b0, en_r[5], 1'b0, en_r[4], 1'b0, en_r[3], 1'b0,
                     en_r[2], 1'b0, en_r[1], 1'b0, en_r[0]};
   assign st_wr = reg_write_i && reg_addr_i == 4'h1;
   assign en_nxt = st_wr ? {reg_wdata_i[12], reg_wdata_i[10], reg_wdata_i[8], reg_wdata_i[6],
                            reg_wdata_i[4], reg_wdata_i[2], reg_wdata_i[0]} : en_r;
   always_ff @(posedge clk_i) begin
      if (reset_i) en_r <= 7'h00;
      else if (ce_i) en_r <= en_nxt;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   chk_status_top: assert property (
      ce_i && reg_read_i && reg_addr_i == 4'h1 |=> reg_rdata_o[15:14] == 2'h0)
      else $error("status top bits not zero");
   chk_phase_lvl: assert property (
      ce_i && reg_read_i && reg_addr_i == 4'h0
      |=> reg_rdata_o[1:0] == $past({phase_b_level_o, phase_a_level_o}))
      else $error("phase levels differ from io control read");
   chk_enable_rw: assert property (
      ce_i && reg_read_i && reg_addr_i == 4'h1
      |=> (reg_rdata_o & 16'h1555) == $past(en_word))
      else $error("enable bits not read back");
   chk_irq_gate: assert property (
      irq_req_o != 7'h00 |-> (irq_req_o & ~$past(en_r)) == 7'h00)
      else $error("request without enable");
   chk_marker_pulse: assert property (irq_req_o[0] |=> !irq_req_o[0])
      else $error("marker request longer than one cycle");
   chk_home_pulse: assert property (irq_req_o[1] |=> !irq_req_o[1])
      else $error("home request longer than one cycle");
   chk_homing_mode: assert property (
      irq_req_o[3] |-> $past(position_init_select_i) inside {3'h3, 3'h4})
      else $error("homing request outside homing modes");
   chk_reset_quiet: assert property ($fell(reset_i) |-> irq_req_o == 7'h00)
      else $error("request right after reset");
endmodule
bind qsc_top qsc_top_chk qsc_top_chk_inst (
   .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
   .reg_rdata_o(reg_rdata_o), .phase_a_level_o(phase_a_level_o),
   .phase_b_level_o(phase_b_level_o), .irq_req_o(irq_req_o),
   .position_init_select_i(position_init_select_i));
`default_nettype wire

// [sim/test_qsc_top.sv]
// Register-level test of the quadrature status counters.
`timescale 1ns/10ps
`default_nettype none
module test_qsc_top;
   logic        clk_i = 1'b0;
   logic        reset_i = 1'b1;
   logic [3:0]  reg_addr_i = 4'h0;
   logic [15:0] reg_wdata_i = 16'h0000;
   logic        reg_write_i = 1'b0;
   logic        reg_read_i = 1'b0;
   logic        count_up_i = 1'b0;
   logic        count_down_i = 1'b0;
   logic [2:0]  position_init_select_i = 3'h0;
   logic        ce_i = 1'b1;
   logic [31:0] upper_cmp = 32'h0000_0010;
   logic [31:0] lower_cmp = 32'h0000_0008;
   logic [31:0] init_val = 32'h0000_000c;
   wire  [15:0] reg_rdata_o;
   wire  [6:0]  irq_req_o;
   wire         a_pin, b_pin, m_pin, h_pin, a_lvl, b_lvl;
   int          err_total = 0;
   int          compares = 0;
   int          irq_seen [7] = '{default: 0};
   qsc_top qsc_top_inst (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
      .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .phase_a_pin_i(a_pin),
      .phase_b_pin_i(b_pin), .marker_pin_i(m_pin), .home_pin_i(h_pin),
      .count_up_i(count_up_i), .count_down_i(count_down_i),
      .position_init_select_i(position_init_select_i),
      .upper_compare_value_i(upper_cmp), .lower_compare_value_i(lower_cmp),
      .init_capture_value_i(init_val), .phase_a_level_o(a_lvl),
      .phase_b_level_o(b_lvl), .irq_req_o(irq_req_o));
   qsc_enc_model qsc_enc_model_inst (.clk_i(clk_i), .phase_a_pin_o(a_pin),
      .phase_b_pin_o(b_pin), .marker_pin_o(m_pin), .home_pin_o(h_pin));
   initial begin
      forever #50 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      for (int k = 0; k < 7; k++) if (irq_req_o[k] === 1'b1) irq_seen[k]++;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_i);
      reg_write_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge clk_i);
      reg_write_i <= 1'b0;
   endtask
   // Read data stand for one cycle only, so they are sampled just after the answer edge.
   task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
      @(posedge clk_i);
      reg_read_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge clk_i);
      reg_read_i <= 1'b0;
      #1 chk(reg_rdata_o & m, e);
   endtask
   task automatic cnt(input logic dn);
      @(posedge clk_i);
      count_down_i <= dn;
      count_up_i <= !dn;
      @(posedge clk_i);
      {count_down_i, count_up_i} <= 2'h0;
   endtask
   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      #500000;
      err_total++;
      tally_and_finish();
   end
   initial begin
      repeat (4) @(posedge clk_i);
      reset_i <= 1'b0;
      for (logic [4:0] a = 5'h00; a < 5'h10; a++)
         rd(a[3:0], 16'hffff, (a == 5'h01) ? 16'h0800 : 16'h0000);
      wr(4'h0, 16'hfe4f);
      rd(4'h0, 16'hffff, 16'hfe44);
      qsc_enc_model_inst.set_ab(2'b10);
      wr(4'h0, 16'h0100);
      rd(4'h0, 16'h0003, 16'h0002);
      chk({b_lvl, a_lvl}, 2'b10);
      wr(4'h0, 16'h0010);
      rd(4'h0, 16'h0003, 16'h0000);
      wr(4'h0, 16'h0000);
      qsc_enc_model_inst.set_ab(2'b00);
      wr(4'h5, 16'h1234);
      rd(4'h5, 16'hffff, 16'h1234);
      @(posedge clk_i) ce_i <= 1'b0;
      wr(4'h5, 16'h5678);
      ce_i <= 1'b1;
      rd(4'h5, 16'hffff, 16'h1234);
      for (logic [3:0] i = 4'h0; i < 4'h8; i += 4'h4) begin
         wr(i + 4'h4, 16'hbeef);
         wr(i + 4'h3, 16'h1234);
         rd(i + 4'h3, 16'hffff, 16'h1234);
         rd(i + 4'h4, 16'hffff, 16'hbeef);
         rd(i + 4'h2, 16'hffff, 16'hbeef);
         wr(i + 4'h2, 16'h0001);
         rd(i + 4'h3, 16'hffff, 16'h1234);
         rd(i + 4'h4, 16'hffff, 16'h0001);
      end
      wr(4'h4, 16'h0000);
      wr(4'h3, 16'h0000);
      wr(4'h5, 16'h0000);
      rd(4'h1, 16'h02aa, 16'h0002);
      cnt(1'b1);
      rd(4'h1, 16'h02aa, 16'h0220);
      rd(4'h3, 16'hffff, 16'hffff);
      rd(4'h5, 16'hffff, 16'hffff);
      cnt(1'b0);
      rd(4'h1, 16'h02aa, 16'h0220);
      rd(4'h1, 16'h02aa, 16'h0000);
      wr(4'h4, 16'h0000);
      wr(4'h3, 16'h0009);
      rd(4'h1, 16'h2800, 16'h0800);
      rd(4'h1, 16'h2800, 16'h0000);
      repeat (7) cnt(1'b0);
      rd(4'h1, 16'h2800, 16'h2000);
      repeat (8) cnt(1'b1);
      rd(4'h1, 16'h2800, 16'h2800);
      rd(4'h1, 16'h2800, 16'h0800);
      wr(4'h1, 16'h1555);
      rd(4'h1, 16'h1555, 16'h1555);
      qsc_enc_model_inst.pulse(1'b1);
      rd(4'h1, 16'h000a, 16'h0002);
      chk(irq_seen[0], 1);
      rd(4'h7, 16'hffff, 16'h1235);
      qsc_enc_model_inst.pulse(1'b0);
      rd(4'h1, 16'h008a, 16'h0008);
      chk(irq_seen[1], 1);
      wr(4'h1, 16'h0000);
      qsc_enc_model_inst.pulse(1'b1);
      rd(4'h1, 16'h0002, 16'h0002);
      chk(irq_seen[0], 1);
      position_init_select_i <= 3'h3;
      qsc_enc_model_inst.pulse(1'b0);
      qsc_enc_model_inst.pulse(1'b1);
      rd(4'h3, 16'hffff, 16'h000c);
      rd(4'h1, 16'h0080, 16'h0080);
      position_init_select_i <= 3'h4;
      init_val <= 32'h0001_0007;
      wr(4'h3, 16'h0009);
      qsc_enc_model_inst.pulse(1'b0);
      qsc_enc_model_inst.pulse(1'b1);
      rd(4'h3, 16'hffff, 16'h0009);
      rd(4'h1, 16'h0080, 16'h0000);
      qsc_enc_model_inst.pulse(1'b1);
      rd(4'h3, 16'hffff, 16'h0007);
      rd(4'h4, 16'hffff, 16'h0001);
      rd(4'h1, 16'h0080, 16'h0080);
      tally_and_finish();
   end
endmodule
`default_nettype wire
